//--- core/pesm_top.sv
// Event status and interrupt mask registers of the transceiver management port
//
// Summary of operation
// - Summary bit flags changes since last read
// - Link-down flag set when no valid link
// - Scrambler-lock-lost flag on descrambler sync loss
// - Bad-code-group flag on invalid code group
// - Missing-stream-start flag on absent start delimiter
// - Missing-stream-end flag on absent end delimiter
// - Polarity-reversed and overlong-transmit flags likewise
// - Rate indicator 1 at 100 Mb/s, resets 1
// - Duplex indicator 1 in full duplex
// - Six lowest status bits read zero
// - One mask bit per event, same position
// - Mask bits 15..4 reset to one, low nibble to zero
`timescale 1ns/1ps
`default_nettype none

module pesm_top
  import pesm_pkg::*;
(
  input  wire logic        clk_sys,      // 100 MHz device clock
  input  wire logic        sys_rst,      // Asynchronous reset, active high
  input  wire logic        clk_en,       // Freezes all state while low
  input  wire pesm_cond_t  cond_in,      // Current receive-path conditions
  input  wire pesm_req_t   mgmt_req,     // Management port request
  output logic [15:0]      mgmt_rdata,   // Read data, registered
  output logic             mgmt_rvalid,  // One-cycle pulse with read data
  output logic             int_req       // Interrupt request, active high
);

  // Register state
  logic [8:0]  stat_reg;      // Visible status bits 14..6
  logic [8:0]  stat_next;
  logic [8:0]  pend_reg;      // Per-bit change since last status read
  logic [8:0]  pend_next;
  logic [15:0] mask_reg;      // Suppress mask
  logic [15:0] mask_next;
  logic [15:0] rdata_reg;     // Read data holding
  logic [15:0] rdata_next;
  logic        rvalid_reg;    // Read answer strobe
  logic        rvalid_next;
  logic        irq_reg;       // Interrupt request
  logic        irq_next;

  // Decoded strobes
  logic        read_stat;     // Status register read this cycle
  logic        write_mask;    // Mask register written this cycle
  logic [8:0]  cond_vec;      // Conditions as a plain vector

  // Next-state logic for every register
  always_comb begin
    cond_vec   = cond_in;
    read_stat  = mgmt_req.rd && (mgmt_req.addr == PESM_ADDR_STATUS);
    write_mask = mgmt_req.wr && (mgmt_req.addr == PESM_ADDR_MASK);

    // latch until read
    // Latched bits keep their 1; the read drops them back to the live view.
    // The live condition is ORed in on the read too, so an event in the
    // read cycle itself is not lost.
    if (read_stat) begin
      stat_next = cond_vec;
    end else begin
      stat_next = (stat_reg & PESM_LATCH_BITS) | cond_vec;
    end

    // change since read
    // Clear on read, but a change in the same cycle sets it again.
    pend_next = (read_stat ? 9'h000 : pend_reg) | (stat_next ^ stat_reg);

    // per-event mask write
    // Reserved pair is plain storage; software is trusted to keep it at 1.
    if (write_mask) begin
      mask_next = mgmt_req.wdata & PESM_MASK_WR;
    end else begin
      mask_next = mask_reg;
    end

    // Read mux; unmapped indices answer zero
    rvalid_next = mgmt_req.rd;
    rdata_next  = rdata_reg;
    if (mgmt_req.rd) begin
      unique case (mgmt_req.addr)
        PESM_ADDR_STATUS: rdata_next = {|pend_reg, stat_reg, 6'h00};
        PESM_ADDR_MASK:   rdata_next = mask_reg & PESM_MASK_WR;
        default:          rdata_next = 16'h0000;
      endcase
    end

    // unmasked changes only
    // The summary bit has its own mask: with it open, any change raises.
    // Event masks sit at the same positions as their status bits, 14..6,
    // so the pending vector lines up with the mask slice from bit 6.
    irq_next = (|(pend_next & ~mask_next[PESM_POS_EVT_LO +: PESM_NUM_EVT]))
             | ((|pend_next) & ~mask_next[PESM_POS_INT]);
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stat_reg   <= PESM_STAT_RST;
      pend_reg   <= 9'h000;
      mask_reg   <= PESM_MASK_RST;
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end else if (clk_en) begin
      stat_reg   <= stat_next;
      pend_reg   <= pend_next;
      mask_reg   <= mask_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      irq_reg    <= irq_next;
    end
  end

  // Outputs straight from flops
  assign mgmt_rdata  = rdata_reg;
  assign mgmt_rvalid = rvalid_reg;
  assign int_req     = irq_reg;

  // Checks on the register behaviour

  a_summary_on_change: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && (stat_next != stat_reg)) |=> (|pend_reg))
    else $error("summary bit missed a change");

  a_link_down_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && cond_in.link_down) |=> stat_reg[8])
    else $error("link-down flag not set");

  a_flags_hold: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && !read_stat && (|(stat_reg & PESM_LATCH_BITS)))
      |=> ((stat_reg & PESM_LATCH_BITS) == ($past(stat_reg) & PESM_LATCH_BITS)
           || (stat_reg & $past(stat_reg) & PESM_LATCH_BITS) == ($past(stat_reg) & PESM_LATCH_BITS)))
    else $error("latched flag dropped without a read");

  // A status read drops every latched bit back to the live view,
  // so the next edge must show exactly what the receive path reported.
  a_read_reloads: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && read_stat) |=> (stat_reg == $past(cond_vec)))
    else $error("status not refreshed after read");

  a_rate_live: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && !read_stat) |=> (stat_reg[1] == $past(cond_in.rate_100)))
    else $error("rate indicator wrong");

  a_duplex_live: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    clk_en |=> (stat_reg[0] == $past(cond_in.full_dup)))
    else $error("duplex indicator wrong");

  a_status_low_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && read_stat) |=> (mgmt_rvalid && mgmt_rdata[5:0] == 6'h00))
    else $error("reserved status bits not zero");

  a_mask_write: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && write_mask) |=> (mask_reg == ($past(mgmt_req.wdata) & PESM_MASK_WR)))
    else $error("mask write not stored");

  a_mask_nibble_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    mask_reg[3:0] == 4'h0)
    else $error("mask low nibble not zero");

  a_masked_quiet: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && (&mask_next[15:6])) |=> !int_req)
    else $error("interrupt raised while fully masked");

  a_unmasked_raise: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && (|(pend_next & ~mask_next[14:6]))) |=> int_req)
    else $error("unmasked change did not interrupt");

  a_summary_irq_raise: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && (|pend_next) && !mask_next[PESM_POS_INT]) |=> int_req)
    else $error("open summary mask did not interrupt");

  // Each event seen on an enabled edge shows in its flag at the next one
  a_lock_lost_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && cond_in.lock_lost) |=> stat_reg[7])
    else $error("lock-lost flag not set");

  a_bad_code_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && cond_in.bad_code) |=> stat_reg[6])
    else $error("bad-code-group flag not set");

  a_start_delim_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && cond_in.no_ssd) |=> stat_reg[5])
    else $error("missing-stream-start flag not set");

  a_end_delim_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && cond_in.no_esd) |=> stat_reg[4])
    else $error("missing-stream-end flag not set");

  a_polarity_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && cond_in.pol_rev) |=> stat_reg[3])
    else $error("polarity-reversed flag not set");

  a_jabber_latch: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (clk_en && cond_in.jabber) |=> stat_reg[2])
    else $error("overlong-transmit flag not set");

endmodule // pesm_top

`default_nettype wire

//--- inc/pesm_pkg.sv
// Package: register map, layouts and reset values for the event status and mask block
package pesm_pkg;
  // Management port register indices
  localparam logic [4:0]  PESM_ADDR_STATUS = 5'h12;
  localparam logic [4:0]  PESM_ADDR_MASK   = 5'h13;
  // Field positions
  localparam int          PESM_POS_INT     = 15;
  localparam int          PESM_POS_EVT_LO  = 6;
  localparam int          PESM_NUM_EVT     = 9;
  // Event bits that latch high until read (link down .. overlong transmit)
  localparam logic [8:0]  PESM_LATCH_BITS  = 9'h1FC;
  // Status reset view: rate indicator at 1, all others 0
  localparam logic [8:0]  PESM_STAT_RST    = 9'h002;
  // Mask reset: everything suppressed, reserved pair at 1, low nibble 0
  localparam logic [15:0] PESM_MASK_RST    = 16'hFFF0;
  // Writable mask bits; the low nibble always reads 0
  localparam logic [15:0] PESM_MASK_WR     = 16'hFFF0;

  // Conditions from the receive path, ordered as status bits 14 down to 6
  typedef struct packed {
    logic link_down;      // No valid link
    logic lock_lost;      // Descrambler out of sync
    logic bad_code;       // Invalid five-bit code group
    logic no_ssd;         // Missing start-of-stream delimiter
    logic no_esd;         // Missing end-of-stream delimiter
    logic pol_rev;        // Receive polarity reversed
    logic jabber;         // Overlong transmit
    logic rate_100;       // 1 = 100 Mb/s, 0 = 10 Mb/s
    logic full_dup;       // 1 = full duplex
  } pesm_cond_t;

  // Management port request
  typedef struct packed {
    logic        rd;      // Read strobe, one cycle
    logic        wr;      // Write strobe, one cycle
    logic [4:0]  addr;    // Register index
    logic [15:0] wdata;   // Write data
  } pesm_req_t;
endpackage

//--- bench/pesm_mgmt_model.sv
// Management controller model for the register port
`timescale 1ns/1ps
`default_nettype none
module pesm_mgmt_model
  import pesm_pkg::*;
(
  input  wire logic        clk_sys,     // Device clock
  input  wire logic [15:0] mgmt_rdata,  // Read data
  input  wire logic        mgmt_rvalid, // Read data valid
  output var  pesm_req_t   mgmt_req     // Request to the block
);
  initial mgmt_req = '0;
  // One access; strobe held for exactly one sampled edge
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    int n;
    n = 0;
    q = 16'h0000;
    @(posedge clk_sys);
    mgmt_req <= {~wr, wr, a, d | 16'h0030};
    @(posedge clk_sys);
    mgmt_req <= '0;
    // Bounded wait so a dead port cannot hang us
    while (!wr && n < 4) begin
      #1;
      if (mgmt_rvalid === 1'b1) begin
        q = mgmt_rdata;
        n = 4;
      end else begin
        @(posedge clk_sys);
        n++;
      end
    end
  endtask
endmodule // pesm_mgmt_model
`default_nettype wire

//--- bench/phy_event_status_mask_tb.sv
// Self-checking bench for the event status and mask block
`timescale 1ns/1ps
`default_nettype none
module phy_event_status_mask_tb import pesm_pkg::*;;
  logic        clk_sys, sys_rst, clk_en, int_req, mgmt_rvalid;
  logic [15:0] mgmt_rdata, q;
  pesm_cond_t  cond_in;
  pesm_req_t   mgmt_req;
  int          n_fail, check_count, cyc;
  pesm_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .cond_in(cond_in),
    .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .int_req(int_req));
  pesm_mgmt_model MGR (.clk_sys(clk_sys), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .mgmt_req(mgmt_req));
  // Clock and cycle ceiling
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    MGR.access(1'b0, a, 16'h0000, q);
    check(q, exp);
  endtask
  // One-cycle event on a condition bit
  task automatic pulse(input int i);
    @(posedge clk_sys);
    cond_in[i] <= 1'b1;
    @(posedge clk_sys);
    cond_in[i] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic t_reset();
    check({15'h0, int_req}, 16'h0000);
    rd(PESM_ADDR_MASK, 16'hFFF0);
    MGR.access(1'b1, PESM_ADDR_STATUS, 16'hFFFF, q);
    rd(PESM_ADDR_STATUS, 16'h0080);
    rd(5'h14, 16'h0000);
  endtask
  // Masked events latch but raise nothing
  task automatic t_latch();
    for (int i = 2; i < 9; i++) begin
      pulse(i);
      check({15'h0, int_req}, 16'h0000);
      rd(PESM_ADDR_STATUS, 16'h8080 | (16'h0001 << (6 + i)));
      rd(PESM_ADDR_STATUS, 16'h8080);
      rd(PESM_ADDR_STATUS, 16'h0080);
    end
  endtask
  task automatic t_live();
    @(posedge clk_sys);
    cond_in <= 9'h001;
    repeat (3) @(posedge clk_sys);
    rd(PESM_ADDR_STATUS, 16'h8040);
    rd(PESM_ADDR_STATUS, 16'h0040);
    @(posedge clk_sys);
    cond_in <= 9'h002;
    repeat (3) @(posedge clk_sys);
    rd(PESM_ADDR_STATUS, 16'h8080);
    rd(PESM_ADDR_STATUS, 16'h0080);
  endtask
  task automatic t_irq();
    MGR.access(1'b1, PESM_ADDR_MASK, 16'hBFFF, q);
    rd(PESM_ADDR_MASK, 16'hBFF0);
    pulse(8);
    check({15'h0, int_req}, 16'h0001);
    rd(PESM_ADDR_STATUS, 16'hC080);
    rd(PESM_ADDR_STATUS, 16'h8080);
    repeat (3) @(posedge clk_sys);
    check({15'h0, int_req}, 16'h0000);
    MGR.access(1'b1, PESM_ADDR_MASK, 16'h7FFF, q);
    pulse(2);
    check({15'h0, int_req}, 16'h0001);
    rd(PESM_ADDR_STATUS, 16'h8180);
    rd(PESM_ADDR_STATUS, 16'h8080);
    check({15'h0, int_req}, 16'h0000);
    MGR.access(1'b1, PESM_ADDR_MASK, 16'hFFFF, q);
  endtask
  // Frozen clock enable: a condition seen only while low never latches
  task automatic t_freeze();
    @(posedge clk_sys);
    clk_en <= 1'b0;
    cond_in <= 9'h102;
    repeat (3) @(posedge clk_sys);
    clk_en <= 1'b1;
    cond_in <= 9'h002;
    check({15'h0, int_req}, 16'h0000);
    rd(PESM_ADDR_STATUS, 16'h0080);
  endtask
  // Reset in mid-run puts the mask back to all suppressed
  task automatic t_rerst();
    MGR.access(1'b1, PESM_ADDR_MASK, 16'h0000, q);
    rd(PESM_ADDR_MASK, 16'h0030);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(PESM_ADDR_MASK, 16'hFFF0);
    rd(PESM_ADDR_STATUS, 16'h0080);
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    cond_in = 9'h002;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_latch();
    t_live();
    t_irq();
    t_freeze();
    t_rerst();
    summarize();
  end
endmodule // phy_event_status_mask_tb
`default_nettype wire
